/* File: pcie_cap_pkg.sv */
// constants and carrier types for the express capability register bank
`default_nettype none
package pcie_cap_pkg;
	// ************************************************
	// bus geometry and register offsets
	// ************************************************
	localparam int unsigned ADDR_W              = 12;
	localparam int unsigned DATA_W              = 32;
	localparam int unsigned STRB_W              = 4;
	localparam logic [11:0] OFS_CAP_HEADER      = 12'h040;
	localparam logic [11:0] OFS_DEV_CAPS        = 12'h044;
	localparam logic [11:0] OFS_BANK_CONTROL    = 12'h0F0;
	localparam logic [11:0] OFS_BANK_STATUS     = 12'h0F4;

	// ************************************************
	// capability header field positions
	// ************************************************
	localparam int unsigned POS_CAP_ID          = 0;
	localparam int unsigned POS_NEXT_PTR        = 8;
	localparam int unsigned POS_REVISION        = 16;
	localparam int unsigned POS_PORT_TYPE       = 20;
	localparam int unsigned POS_SLOT            = 24;
	localparam int unsigned POS_MSI_NUM         = 25;
	localparam int unsigned POS_TC_ROUTING      = 30;

	// ************************************************
	// device capabilities field positions
	// ************************************************
	localparam int unsigned POS_MAX_PAYLOAD     = 0;
	localparam int unsigned POS_PHANTOM         = 3;
	localparam int unsigned POS_EXT_TAG         = 5;
	localparam int unsigned POS_L0S_LAT         = 6;
	localparam int unsigned POS_L1_LAT          = 9;
	localparam int unsigned POS_ATTN_BUTTON     = 12;
	localparam int unsigned POS_ATTN_IND        = 13;
	localparam int unsigned POS_PWR_IND         = 14;
	localparam int unsigned POS_ROLE_ERR        = 15;
	localparam int unsigned POS_PWR_VALUE       = 18;
	localparam int unsigned POS_PWR_SCALE       = 26;

	// ************************************************
	// bank control and status bit positions
	// ************************************************
	localparam int unsigned POS_CTRL_LOCK       = 0;
	localparam int unsigned POS_STS_UPSTREAM    = 0;
	localparam int unsigned POS_STS_COMPAT      = 1;
	localparam int unsigned POS_STS_LOADED      = 2;
	localparam int unsigned POS_STS_MSG_SEEN    = 3;

	// ************************************************
	// constant field values and values after reset
	// ************************************************
	localparam logic [7:0]  CAP_ID_VALUE        = 8'h10;
	localparam logic [7:0]  RST_NEXT_PTR        = 8'hC0;
	localparam logic [3:0]  RST_REVISION_COMPAT = 4'h1;
	localparam logic [3:0]  RST_REVISION_NATIVE = 4'h2;
	localparam logic [3:0]  TYPE_UPSTREAM       = 4'h5;
	localparam logic [3:0]  TYPE_DOWNSTREAM     = 4'h6;
	localparam logic        RST_SLOT            = 1'h0;
	localparam logic [4:0]  MSI_NUM_VALUE       = 5'h00;
	localparam logic        RST_TC_ROUTING      = 1'h1;
	localparam logic        RST_TC_ROUTING_COMP = 1'h0;
	localparam logic [2:0]  RST_MAX_PAYLOAD     = 3'h1;
	localparam logic [1:0]  PHANTOM_VALUE       = 2'h0;
	localparam logic        RST_EXT_TAG         = 1'h1;
	localparam logic [2:0]  LATENCY_VALUE       = 3'h0;
	localparam logic        PRESENT_VALUE       = 1'h0;
	localparam logic        ROLE_ERR_VALUE      = 1'h1;
	localparam logic        RST_LOCK            = 1'h0;
	localparam logic [7:0]  RST_PWR_VALUE       = 8'h00;
	localparam logic [1:0]  RST_PWR_SCALE       = 2'h0;
	localparam logic [31:0] RST_PRDATA          = 32'h0000_0000;

	// ************************************************
	// carrier types and strap sequencing states
	// ************************************************
	typedef struct packed {
		logic       valid;
		logic [7:0] value;
		logic [1:0] scale;
	} pwr_msg_t;

	typedef struct packed {
		logic [7:0] value;
		logic [1:0] scale;
	} pwr_limit_t;

	typedef enum logic [1:0] {
		STRAP_WAIT1 = 2'b00,
		STRAP_WAIT2 = 2'b01,
		STRAP_LOAD  = 2'b11,
		STRAP_RUN   = 2'b10
	} strap_state_t;
endpackage
`default_nettype wire

/* File: strap_sync.sv */
// two flip-flop synchroniser for the port straps
`default_nettype none
module strap_sync (
	input  wire logic       core_clk, // core clock
	input  wire logic       nrst,     // async reset, active low
	input  wire logic [1:0] pinIn,    // raw strap pins
	output logic      [1:0] syncOut   // synchronised straps
);
	logic [1:0] stage1_r;
	logic [1:0] stage1_nxt;
	logic [1:0] stage2_nxt;

	always_comb begin
		stage1_nxt = pinIn;
		stage2_nxt = stage1_r;
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			stage1_r <= 2'h0;
			syncOut  <= 2'h0;
		end else begin
			stage1_r <= stage1_nxt;
			syncOut  <= stage2_nxt;
		end
	end
endmodule
`default_nettype wire

/* File: pwr_limit_capture.sv */
// holder for the slot power limit taken from received limit messages
`default_nettype none
module pwr_limit_capture (
	input  wire logic                   core_clk, // core clock
	input  wire logic                   nrst,     // async reset, active low
	input  wire logic                   enable,   // capture allowed (upstream port)
	input  wire pcie_cap_pkg::pwr_msg_t msg,      // decoded limit message
	output pcie_cap_pkg::pwr_limit_t    limit_r,  // captured value and scale
	output logic                        seen      // one-cycle pulse on capture
);
	pcie_cap_pkg::pwr_limit_t limit_nxt;

	always_comb begin
		limit_nxt = limit_r;
		seen      = 1'b0;
		if (enable && msg.valid) begin
			limit_nxt.value = msg.value;
			limit_nxt.scale = msg.scale;
			seen            = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			limit_r.value <= pcie_cap_pkg::RST_PWR_VALUE;
			limit_r.scale <= pcie_cap_pkg::RST_PWR_SCALE;
		end else begin
			limit_r <= limit_nxt;
		end
	end
endmodule
`default_nettype wire

/* File: pcie_capability_regs.sv */
// express capability header and device capabilities register bank on apb
//
// Contract
// - The header reads the fixed capability identifier 0x10 in bits 7:0.
// - Bits 15:8 hold the next capability offset, 0xC0 after reset, writable while unlocked.
// - Bits 19:16 hold the structure revision, 1 in compatibility mode, writable while unlocked.
// - Bits 23:20 read 0x5 on the upstream port and 0x6 on a downstream port.
// - Bit 24 flags a slot, resets to zero and stays zero on the upstream port.
// - Bits 29:25 of the header always read zero.
// - Bit 30 flags traffic-class routing, 1 after reset or 0 in compatibility mode, writable while unlocked.
// - Device capability bits 2:0 give max payload, 1 (256 bytes) after reset, writable while unlocked.
// - Device capability bits 4:3 always read zero.
// - Bit 5 flags extended tags, 1 after reset, writable while unlocked.
// - The endpoint latency fields in bits 8:6 and 11:9 always read zero.
// - The button and indicator presence bits 12, 13 and 14 always read zero.
// - Bit 15 always reads one for role-based error reporting.
// - Bits 25:18 hold the limit value of the last message on upstream, zero downstream.
// - Bits 27:26 hold the limit scale of the last message on upstream, zero downstream.
`default_nettype none
module pcie_capability_regs (
	input  wire logic                   core_clk,     // core clock, 20 MHz
	input  wire logic                   nrst,         // async reset, active low
	input  wire logic                   psel,         // apb select
	input  wire logic                   penable,      // apb access phase
	input  wire logic                   pwrite,       // apb direction, high for write
	input  wire logic [11:0]            paddr,        // apb byte address
	input  wire logic [31:0]            pwdata,       // apb write data
	input  wire logic [3:0]             pstrb,        // apb write byte strobes
	output logic      [31:0]            prdata,       // apb read data
	output logic                        pready,       // apb transfer done
	output logic                        pslverr,      // apb error for unmapped address
	input  wire logic                   upstreamPin,  // strap: high for upstream port
	input  wire logic                   compatPin,    // strap: high for 1.1 compatibility mode
	input  wire pcie_cap_pkg::pwr_msg_t pwrMsg        // received power limit message
);
	// ************************************************
	// helpers
	// ************************************************
	function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
		input logic [31:0] newVal, input logic [3:0] strb);
		logic [31:0] res;
		res = oldVal;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = newVal[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// ************************************************
	// declarations
	// ************************************************
	logic [1:0]                 strapSync;
	pcie_cap_pkg::strap_state_t strapState_r;
	pcie_cap_pkg::strap_state_t strapState_nxt;
	logic                       upstream_r;
	logic                       upstream_nxt;
	logic                       compat_r;
	logic                       compat_nxt;
	logic                       loaded_r;
	logic                       loaded_nxt;

	logic [7:0]                 nextPtr_r;
	logic [7:0]                 nextPtr_nxt;
	logic [3:0]                 revision_r;
	logic [3:0]                 revision_nxt;
	logic                       slot_r;
	logic                       slot_nxt;
	logic                       tcRouting_r;
	logic                       tcRouting_nxt;
	logic [2:0]                 maxPayload_r;
	logic [2:0]                 maxPayload_nxt;
	logic                       extTag_r;
	logic                       extTag_nxt;
	logic                       lock_r;
	logic                       lock_nxt;
	logic                       msgSeen_r;
	logic                       msgSeen_nxt;

	logic [31:0]                prdata_nxt;
	logic                       pready_nxt;
	logic                       pslverr_nxt;

	pcie_cap_pkg::pwr_limit_t   pwrLimit;
	logic                       pwrSeen;
	logic [31:0]                headerWord;
	logic [31:0]                devCapsWord;
	logic [31:0]                controlWord;
	logic [31:0]                statusWord;
	logic [31:0]                wordIn;
	logic                       writeTaken;
	logic                       hitHeader;
	logic                       hitDevCaps;
	logic                       hitControl;
	logic                       hitStatus;

	// ************************************************
	// straps and captured power limit
	// ************************************************
	strap_sync u_strap_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.pinIn    ({compatPin, upstreamPin}),
		.syncOut  (strapSync)
	);

	pwr_limit_capture u_pwr_limit_capture (
		.core_clk (core_clk),
		.nrst     (nrst),
		.enable   (upstream_r && loaded_r),
		.msg      (pwrMsg),
		.limit_r  (pwrLimit),
		.seen     (pwrSeen)
	);

	// ************************************************
	// read words
	// ************************************************
	always_comb begin
		headerWord = 32'h0000_0000;
		headerWord[pcie_cap_pkg::POS_CAP_ID +: 8]    = pcie_cap_pkg::CAP_ID_VALUE;
		headerWord[pcie_cap_pkg::POS_NEXT_PTR +: 8]  = nextPtr_r;
		headerWord[pcie_cap_pkg::POS_REVISION +: 4]  = revision_r;
		headerWord[pcie_cap_pkg::POS_PORT_TYPE +: 4] = upstream_r ?
			pcie_cap_pkg::TYPE_UPSTREAM : pcie_cap_pkg::TYPE_DOWNSTREAM;
		headerWord[pcie_cap_pkg::POS_SLOT]           = slot_r && !upstream_r;
		headerWord[pcie_cap_pkg::POS_MSI_NUM +: 5]   = pcie_cap_pkg::MSI_NUM_VALUE;
		headerWord[pcie_cap_pkg::POS_TC_ROUTING]     = tcRouting_r;

		devCapsWord = 32'h0000_0000;
		devCapsWord[pcie_cap_pkg::POS_MAX_PAYLOAD +: 3] = maxPayload_r;
		devCapsWord[pcie_cap_pkg::POS_PHANTOM +: 2]     = pcie_cap_pkg::PHANTOM_VALUE;
		devCapsWord[pcie_cap_pkg::POS_EXT_TAG]          = extTag_r;
		devCapsWord[pcie_cap_pkg::POS_L0S_LAT +: 3]     = pcie_cap_pkg::LATENCY_VALUE;
		devCapsWord[pcie_cap_pkg::POS_L1_LAT +: 3]      = pcie_cap_pkg::LATENCY_VALUE;
		devCapsWord[pcie_cap_pkg::POS_ATTN_BUTTON]      = pcie_cap_pkg::PRESENT_VALUE;
		devCapsWord[pcie_cap_pkg::POS_ATTN_IND]         = pcie_cap_pkg::PRESENT_VALUE;
		devCapsWord[pcie_cap_pkg::POS_PWR_IND]          = pcie_cap_pkg::PRESENT_VALUE;
		devCapsWord[pcie_cap_pkg::POS_ROLE_ERR]         = pcie_cap_pkg::ROLE_ERR_VALUE;
		devCapsWord[pcie_cap_pkg::POS_PWR_VALUE +: 8]   = upstream_r ?
			pwrLimit.value : 8'h00;
		devCapsWord[pcie_cap_pkg::POS_PWR_SCALE +: 2]   = upstream_r ?
			pwrLimit.scale : 2'h0;

		controlWord = 32'h0000_0000;
		controlWord[pcie_cap_pkg::POS_CTRL_LOCK] = lock_r;

		statusWord = 32'h0000_0000;
		statusWord[pcie_cap_pkg::POS_STS_UPSTREAM] = upstream_r;
		statusWord[pcie_cap_pkg::POS_STS_COMPAT]   = compat_r;
		statusWord[pcie_cap_pkg::POS_STS_LOADED]   = loaded_r;
		statusWord[pcie_cap_pkg::POS_STS_MSG_SEEN] = msgSeen_r;
	end

	// ************************************************
	// apb slave
	// ************************************************
	always_comb begin
		hitHeader   = (paddr == pcie_cap_pkg::OFS_CAP_HEADER);
		hitDevCaps  = (paddr == pcie_cap_pkg::OFS_DEV_CAPS);
		hitControl  = (paddr == pcie_cap_pkg::OFS_BANK_CONTROL);
		hitStatus   = (paddr == pcie_cap_pkg::OFS_BANK_STATUS);
		// the write lands on the edge where the master sees pready
		writeTaken  = psel && penable && pready && pwrite;
		pready_nxt  = 1'b0;
		pslverr_nxt = 1'b0;
		prdata_nxt  = prdata;
		if (psel && penable && !pready) begin
			pready_nxt  = 1'b1;
			pslverr_nxt = !(hitHeader || hitDevCaps || hitControl || hitStatus);
			if (!pwrite) begin
				if (hitHeader) begin
					prdata_nxt = headerWord;
				end else if (hitDevCaps) begin
					prdata_nxt = devCapsWord;
				end else if (hitControl) begin
					prdata_nxt = controlWord;
				end else if (hitStatus) begin
					prdata_nxt = statusWord;
				end else begin
					prdata_nxt = 32'h0000_0000;
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			prdata  <= pcie_cap_pkg::RST_PRDATA;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= prdata_nxt;
			pready  <= pready_nxt;
			pslverr <= pslverr_nxt;
		end
	end

	// ************************************************
	// strap loading and writable fields
	// ************************************************
	always_comb begin
		strapState_nxt = strapState_r;
		upstream_nxt   = upstream_r;
		compat_nxt     = compat_r;
		loaded_nxt     = loaded_r;
		nextPtr_nxt    = nextPtr_r;
		revision_nxt   = revision_r;
		slot_nxt       = slot_r;
		tcRouting_nxt  = tcRouting_r;
		maxPayload_nxt = maxPayload_r;
		extTag_nxt     = extTag_r;
		lock_nxt       = lock_r;
		msgSeen_nxt    = msgSeen_r;
		wordIn         = 32'h0000_0000;

		if (writeTaken && hitHeader && !lock_r) begin
			wordIn        = mergeBytes(headerWord, pwdata, pstrb);
			nextPtr_nxt   = wordIn[pcie_cap_pkg::POS_NEXT_PTR +: 8];
			revision_nxt  = wordIn[pcie_cap_pkg::POS_REVISION +: 4];
			slot_nxt      = wordIn[pcie_cap_pkg::POS_SLOT] && !upstream_r;
			tcRouting_nxt = wordIn[pcie_cap_pkg::POS_TC_ROUTING];
		end else if (writeTaken && hitDevCaps && !lock_r) begin
			wordIn         = mergeBytes(devCapsWord, pwdata, pstrb);
			maxPayload_nxt = wordIn[pcie_cap_pkg::POS_MAX_PAYLOAD +: 3];
			extTag_nxt     = wordIn[pcie_cap_pkg::POS_EXT_TAG];
		end else if (writeTaken && hitControl) begin
			wordIn   = mergeBytes(controlWord, pwdata, pstrb);
			lock_nxt = wordIn[pcie_cap_pkg::POS_CTRL_LOCK];
		end

		// message flag: a capture in the clearing cycle keeps it set
		if (writeTaken && hitStatus && pstrb[0] && pwdata[pcie_cap_pkg::POS_STS_MSG_SEEN]) begin
			msgSeen_nxt = 1'b0;
		end
		if (pwrSeen) begin
			msgSeen_nxt = 1'b1;
		end

		case (strapState_r)
			pcie_cap_pkg::STRAP_WAIT1: begin
				strapState_nxt = pcie_cap_pkg::STRAP_WAIT2;
			end
			pcie_cap_pkg::STRAP_WAIT2: begin
				strapState_nxt = pcie_cap_pkg::STRAP_LOAD;
			end
			pcie_cap_pkg::STRAP_LOAD: begin
				strapState_nxt = pcie_cap_pkg::STRAP_RUN;
				upstream_nxt   = strapSync[0];
				compat_nxt     = strapSync[1];
				loaded_nxt     = 1'b1;
				revision_nxt   = strapSync[1] ? pcie_cap_pkg::RST_REVISION_COMPAT :
					pcie_cap_pkg::RST_REVISION_NATIVE;
				tcRouting_nxt  = strapSync[1] ? pcie_cap_pkg::RST_TC_ROUTING_COMP :
					pcie_cap_pkg::RST_TC_ROUTING;
				slot_nxt       = pcie_cap_pkg::RST_SLOT;
			end
			pcie_cap_pkg::STRAP_RUN: begin
				strapState_nxt = pcie_cap_pkg::STRAP_RUN;
			end
			default: begin
				strapState_nxt = pcie_cap_pkg::STRAP_WAIT1;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			strapState_r <= pcie_cap_pkg::STRAP_WAIT1;
			upstream_r   <= 1'b0;
			compat_r     <= 1'b0;
			loaded_r     <= 1'b0;
			nextPtr_r    <= pcie_cap_pkg::RST_NEXT_PTR;
			revision_r   <= pcie_cap_pkg::RST_REVISION_COMPAT;
			slot_r       <= pcie_cap_pkg::RST_SLOT;
			tcRouting_r  <= pcie_cap_pkg::RST_TC_ROUTING;
			maxPayload_r <= pcie_cap_pkg::RST_MAX_PAYLOAD;
			extTag_r     <= pcie_cap_pkg::RST_EXT_TAG;
			lock_r       <= pcie_cap_pkg::RST_LOCK;
			msgSeen_r    <= 1'b0;
		end else begin
			strapState_r <= strapState_nxt;
			upstream_r   <= upstream_nxt;
			compat_r     <= compat_nxt;
			loaded_r     <= loaded_nxt;
			nextPtr_r    <= nextPtr_nxt;
			revision_r   <= revision_nxt;
			slot_r       <= slot_nxt;
			tcRouting_r  <= tcRouting_nxt;
			maxPayload_r <= maxPayload_nxt;
			extTag_r     <= extTag_nxt;
			lock_r       <= lock_nxt;
			msgSeen_r    <= msgSeen_nxt;
		end
	end
endmodule
`default_nettype wire

/* File: pcie_capability_regs_props.sv */
// concurrent checks on the apb side of the capability register bank
`default_nettype none
module pcie_capability_regs_props (
	input wire logic        core_clk, // core clock
	input wire logic        nrst,     // async reset, active low
	input wire logic        psel,     // apb select
	input wire logic        penable,  // apb access phase
	input wire logic        pwrite,   // apb direction
	input wire logic [11:0] paddr,    // apb byte address
	input wire logic [31:0] prdata,   // apb read data
	input wire logic        pready,   // apb transfer done
	input wire logic        pslverr   // apb error
);
	// ************************************************
	// read decode and properties
	// ************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire logic rdHdr;
	wire logic rdCap;
	wire logic mapped;
	assign rdHdr = pready && psel && !pwrite && paddr == 12'h040;
	assign rdCap = pready && psel && !pwrite && paddr == 12'h044;
	assign mapped = paddr inside {12'h040, 12'h044, 12'h0F0, 12'h0F4};
	property p_cap_id; rdHdr |-> prdata[7:0] == 8'h10 && !prdata[31]; endproperty
	a_cap_id: assert property (p_cap_id) else $error("bad capability id");
	property p_msi_zero; rdHdr |-> prdata[29:25] == 5'h00; endproperty
	a_msi_zero: assert property (p_msi_zero) else $error("msi number not zero");
	property p_port_type; rdHdr |-> prdata[23:20] inside {4'h5, 4'h6}; endproperty
	a_port_type: assert property (p_port_type) else $error("bad port type");
	property p_up_slot; rdHdr && prdata[23:20] == 4'h5 |-> !prdata[24]; endproperty
	a_up_slot: assert property (p_up_slot) else $error("slot set on upstream");
	property p_hw_zero; rdCap |-> prdata[4:3] == 2'h0 && prdata[14:6] == 9'h000; endproperty
	a_hw_zero: assert property (p_hw_zero) else $error("fixed zero field set");
	property p_role_err; rdCap |-> prdata[15] && prdata[17:16] == 2'h0; endproperty
	a_role_err: assert property (p_role_err) else $error("role error bit wrong");
	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
	property p_ready_cause; pready |-> $past(psel && penable && !pready); endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
	property p_err_unmapped; pready && !mapped |-> pslverr; endproperty
	a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped without error");
	property p_err_mapped; pslverr |-> pready && !mapped; endproperty
	a_err_mapped: assert property (p_err_mapped) else $error("stray error response");
endmodule
`default_nettype wire

/* File: pwr_msg_source.sv */
// link partner model that delivers slot power limit messages
`default_nettype none
module pwr_msg_source (
	input  wire logic             core_clk, // core clock
	input  wire logic             nrst,     // async reset, active low
	input  wire logic             send,     // deliver one message per cycle high
	input  wire logic [7:0]       value,    // limit value to send
	input  wire logic [1:0]       scale,    // limit scale to send
	output pcie_cap_pkg::pwr_msg_t pwrMsg   // message towards the bank
);
	// value and scale together; idle fields toggle
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			pwrMsg <= '0;
		else if (send)
			pwrMsg <= {1'b1, value, scale};
		else
			pwrMsg <= {1'b0, ~pwrMsg.value, ~pwrMsg.scale};
	end
endmodule
`default_nettype wire

/* File: pcie_capability_regs_tb_top.sv */
// self-checking bench for the capability register bank
`default_nettype none
module pcie_capability_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ************************************************
	// signals, instances and tasks
	// ************************************************
	logic                   core_clk    = 1'b0;
	logic                   nrst        = 1'b0;
	logic                   psel        = 1'b0;
	logic                   penable     = 1'b0;
	logic                   pwrite      = 1'b0;
	logic [11:0]            paddr       = 12'h000;
	logic [31:0]            pwdata      = 32'h0000_0000;
	logic [3:0]             pstrb       = 4'h0;
	logic [31:0]            prdata;
	logic                   pready;
	logic                   pslverr;
	logic                   upstreamPin = 1'b1;
	logic                   compatPin   = 1'b0;
	logic                   send        = 1'b0;
	logic [7:0]             msgValue    = 8'h00;
	logic [1:0]             msgScale    = 2'h0;
	pcie_cap_pkg::pwr_msg_t pwrMsg;
	logic [31:0]            rd;
	logic                   er;
	logic [7:0]             v;
	int                     failures    = 0;
	int                     compares    = 0;
	typedef struct {logic [11:0] a; logic [31:0] d; logic e;} row_t;
	row_t rows [6] = '{'{12'h040, 32'h4052_C010, 1'b0}, '{12'h044, 32'h0000_8021, 1'b0},
		'{12'h0F0, 32'h0, 1'b0}, '{12'h0F4, 32'h5, 1'b0}, '{12'h048, 32'h0, 1'b1},
		'{12'h041, 32'h0, 1'b1}};

	initial forever #25 core_clk = ~core_clk;

	pcie_capability_regs pcie_capability_regs_i (.core_clk(core_clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .upstreamPin(upstreamPin),
		.compatPin(compatPin), .pwrMsg(pwrMsg));
	pwr_msg_source pwr_msg_source_i (.core_clk(core_clk), .nrst(nrst), .send(send),
		.value(msgValue), .scale(msgScale), .pwrMsg(pwrMsg));

	task automatic wrap_up;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
		compares++;
		if ((got & msk) !== exp) begin
			failures++;
			$display("Error at %0t: read %h expected %h", $time, got & msk, exp);
		end
	endtask

	task automatic chkBit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: error flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			failures++;
			$display("Error at %0t: no pready", $time);
			wrap_up();
		end
		rd = prdata;
		er = pslverr;
		@(posedge core_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic msg(input logic [7:0] val, input logic [1:0] scl);
		@(posedge core_clk);
		send <= 1'b1;
		msgValue <= val;
		msgScale <= scl;
		@(posedge core_clk);
		send <= 1'b0;
	endtask

	task automatic resetDut(input logic up, input logic comp);
		@(posedge core_clk);
		nrst <= 1'b0;
		upstreamPin <= up;
		compatPin <= comp;
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (5) @(posedge core_clk);
	endtask

	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		resetDut(1'b1, 1'b0);
		foreach (rows[i]) begin
			apb(1'b0, rows[i].a, 32'h0, 4'h0);
			chk(rd, rows[i].d, 32'hFFFF_FFFF);
			chkBit(er, rows[i].e);
		end
		apb(1'b1, 12'h040, 32'hFFFF_FFFF, 4'hF);
		apb(1'b0, 12'h040, 32'h0, 4'h0);
		chk(rd, 32'h405F_FF10, 32'hFFFF_FFFF);
		apb(1'b1, 12'h044, 32'hFFFF_FFFF, 4'hF);
		apb(1'b0, 12'h044, 32'h0, 4'h0);
		chk(rd, 32'h0000_8027, 32'hFFFF_FFFF);
		apb(1'b1, 12'h0F0, 32'h1, 4'hF);
		apb(1'b1, 12'h040, 32'h0, 4'hF);
		apb(1'b0, 12'h040, 32'h0, 4'h0);
		chk(rd, 32'h405F_FF10, 32'hFFFF_FFFF);
		apb(1'b1, 12'h0F0, 32'h0, 4'hF);
		apb(1'b1, 12'h040, 32'h0, 4'h2);
		apb(1'b0, 12'h040, 32'h0, 4'h0);
		chk(rd, 32'h405F_0010, 32'hFFFF_FFFF);
		for (int i = 0; i < 4; i++) begin
			v = 8'h5A + 8'(i);
			msg(v, i[1:0]);
			apb(1'b0, 12'h044, 32'h0, 4'h0);
			chk(rd, {4'h0, i[1:0], v, 18'h0}, 32'h0FFC_0000);
		end
		@(posedge core_clk);
		send <= 1'b1;
		msgValue <= 8'h3C;
		msgScale <= 2'h1;
		@(posedge core_clk);
		msgValue <= 8'h81;
		msgScale <= 2'h2;
		@(posedge core_clk);
		send <= 1'b0;
		apb(1'b0, 12'h044, 32'h0, 4'h0);
		chk(rd, {4'h0, 2'h2, 8'h81, 18'h0}, 32'h0FFC_0000);
		resetDut(1'b0, 1'b1);
		apb(1'b0, 12'h040, 32'h0, 4'h0);
		chk(rd, 32'h0061_C010, 32'hFFFF_FFFF);
		msg(8'hA5, 2'h3);
		apb(1'b0, 12'h044, 32'h0, 4'h0);
		chk(rd, 32'h0000_8021, 32'hFFFF_FFFF);
		apb(1'b1, 12'h040, 32'h0100_0000, 4'h8);
		apb(1'b0, 12'h040, 32'h0, 4'h0);
		chk(rd, 32'h0161_C010, 32'hFFFF_FFFF);
		wrap_up();
	end
endmodule

bind pcie_capability_regs pcie_capability_regs_props pcie_capability_regs_props_i (
	.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire
